// [verilog/dstp_pkg.sv]
// package of constants for the dual slope pwm timer block
// assumes a 32-bit axi4-lite register bus and one 250 MHz clock
package dstp_pkg;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [4:0] DSTP_OFF_CTRL = 5'h00;
  localparam logic [4:0] DSTP_OFF_CMP = 5'h04;
  localparam logic [4:0] DSTP_OFF_CMPA = 5'h08;
  localparam logic [4:0] DSTP_OFF_CNT = 5'h0c;
  localparam logic [4:0] DSTP_OFF_STAT = 5'h10;
  localparam logic [4:0] DSTP_OFF_CLR = 5'h14;
  localparam logic [4:0] DSTP_OFF_IEN = 5'h18;
  localparam logic [4:0] DSTP_OFF_OBS = 5'h1c;

  // ---------------------------------------------------------------
  // control register field positions
  // ---------------------------------------------------------------
  localparam int DSTP_CTRL_WGM_LSB = 0;
  localparam int DSTP_CTRL_OMODE_LSB = 4;
  localparam int DSTP_CTRL_CSEL_LSB = 8;
  localparam int DSTP_CTRL_PINDIR_BIT = 12;
  localparam int DSTP_CTRL_ASYNC_BIT = 13;

  // status, clear and enable layout
  localparam int DSTP_ST_OVF_BIT = 0;
  localparam int DSTP_ST_MATCH_BIT = 1;
  localparam int DSTP_ST_W = 2;

  // ---------------------------------------------------------------
  // mode codes and counter limits
  // ---------------------------------------------------------------
  localparam logic [2:0] DSTP_WGM_PC_FIXED = 3'h1;
  localparam logic [2:0] DSTP_WGM_PC_CMPA = 3'h5;
  localparam logic [1:0] DSTP_OMODE_NONINV = 2'h2;
  localparam logic [1:0] DSTP_OMODE_INV = 2'h3;
  localparam logic [7:0] DSTP_TOP_FIXED = 8'hff;
  localparam logic [7:0] DSTP_BOTTOM = 8'h00;
  localparam int DSTP_PERIOD_TICKS = 510;

  // prescaler: clock select 0 stops the timer, 1..7 pick a factor
  localparam logic [9:0] DSTP_DIV1 = 10'h000;
  localparam logic [9:0] DSTP_DIV8 = 10'h007;
  localparam logic [9:0] DSTP_DIV32 = 10'h01f;
  localparam logic [9:0] DSTP_DIV64 = 10'h03f;
  localparam logic [9:0] DSTP_DIV128 = 10'h07f;
  localparam logic [9:0] DSTP_DIV256 = 10'h0ff;
  localparam logic [9:0] DSTP_DIV1024 = 10'h3ff;

  // reset values and bus response codes
  localparam logic [31:0] DSTP_CTRL_RST = 32'h0000_0000;
  localparam logic [7:0] DSTP_CMP_RST = 8'h00;
  localparam logic [1:0] DSTP_RESP_OKAY = 2'h0;
  localparam logic [1:0] DSTP_RESP_SLVERR = 2'h2;

  // counting direction
  typedef enum logic {
    DSTP_DIR_UP = 1'b0,
    DSTP_DIR_DOWN = 1'b1
  } dstp_dir_t;

endpackage : dstp_pkg

// [verilog/dstp_timer_pwm.sv]
// dual slope (phase correct) pwm timer with an axi4-lite register slave
// assumes aclk at 250 MHz, a synchronous active-low reset and an optional
// timer oscillator on tosc that is asynchronous to aclk
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps

module dstp_timer_pwm (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic tosc,
  input wire logic [4:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [4:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic compare_output,
  output logic compare_output_oe,
  output logic irq
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic [4:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic awready_q, awready_d, wready_q, wready_d;
  logic bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic do_wr, ar_hs;
  logic [31:0] wmask;

  logic [31:0] ctrl_q, ctrl_d;
  logic [7:0] cmp_buf_q, cmp_buf_d, cmp_act_q, cmp_act_d;
  logic [7:0] cmpa_buf_q, cmpa_buf_d, cmpa_act_q, cmpa_act_d;
  logic [1:0] stat_q, stat_d, ien_q, ien_d;
  logic irq_q, irq_d;

  logic tosc_s1_q, tosc_s2_q, tosc_s3_q;
  logic [9:0] pre_q, pre_d;
  logic tick;
  logic [7:0] cnt_q, cnt_d;
  dstp_pkg::dstp_dir_t dir_q, dir_d;
  logic out_q, out_d, oe_q, oe_d;

  logic [2:0] wgm;
  logic [1:0] omode;
  logic [2:0] csel;
  logic pc_mode, pwm_on, src_en;
  logic [7:0] top;
  logic [9:0] div_m1;
  logic ovf_ev, match_ev, at_top;
  logic level;

  // control fields
  assign wgm = ctrl_q[dstp_pkg::DSTP_CTRL_WGM_LSB +: 3];
  assign omode = ctrl_q[dstp_pkg::DSTP_CTRL_OMODE_LSB +: 2];
  assign csel = ctrl_q[dstp_pkg::DSTP_CTRL_CSEL_LSB +: 3];
  assign pc_mode = (wgm == dstp_pkg::DSTP_WGM_PC_FIXED) || (wgm == dstp_pkg::DSTP_WGM_PC_CMPA);
  assign top = (wgm == dstp_pkg::DSTP_WGM_PC_CMPA) ? cmpa_act_q : dstp_pkg::DSTP_TOP_FIXED;
  assign pwm_on = (omode == dstp_pkg::DSTP_OMODE_NONINV) || (omode == dstp_pkg::DSTP_OMODE_INV);

  // ---------------------------------------------------------------
  // axi4-lite write and read channels
  // ---------------------------------------------------------------
  // byte lane mask from the write strobes
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_mask
      assign wmask[gi*8 +: 8] = {8{wstrb_q[gi]}};
    end
  endgenerate

  assign do_wr = aw_have_q && w_have_q && !bvalid_q;
  assign ar_hs = s_axi_arvalid && arready_q;

  // address and data are caught independently, the write fires when both are held
  always_comb
  begin
    aw_have_d = aw_have_q;
    w_have_d = w_have_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    if (s_axi_awvalid && awready_q)
    begin
      aw_have_d = 1'b1;
      awaddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_q)
    begin
      w_have_d = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
    end
    if (do_wr)
    begin
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
      bvalid_d = 1'b1;
      unique case (awaddr_q[4:2])
        3'h0, 3'h1, 3'h2, 3'h3, 3'h5, 3'h6: bresp_d = dstp_pkg::DSTP_RESP_OKAY;
        default: bresp_d = dstp_pkg::DSTP_RESP_SLVERR;
      endcase
      if (awaddr_q[1:0] != 2'h0)
        bresp_d = dstp_pkg::DSTP_RESP_SLVERR;
    end
    else if (bvalid_q && s_axi_bready)
      bvalid_d = 1'b0;
    awready_d = !aw_have_d && !bvalid_d;
    wready_d = !w_have_d && !bvalid_d;
  end

  // read data is sampled at the address handshake and answered one cycle later
  always_comb
  begin
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (ar_hs)
    begin
      rvalid_d = 1'b1;
      rresp_d = dstp_pkg::DSTP_RESP_OKAY;
      rdata_d = 32'h0000_0000;
      unique case (s_axi_araddr)
        dstp_pkg::DSTP_OFF_CTRL: rdata_d = ctrl_q;
        dstp_pkg::DSTP_OFF_CMP: rdata_d = {24'h00_0000, cmp_buf_q};
        dstp_pkg::DSTP_OFF_CMPA: rdata_d = {24'h00_0000, cmpa_buf_q};
        dstp_pkg::DSTP_OFF_CNT: rdata_d = {24'h00_0000, cnt_q};
        dstp_pkg::DSTP_OFF_STAT: rdata_d = {30'h0000_0000, stat_q};
        dstp_pkg::DSTP_OFF_CLR: rdata_d = 32'h0000_0000; // write-only
        dstp_pkg::DSTP_OFF_IEN: rdata_d = {30'h0000_0000, ien_q};
        dstp_pkg::DSTP_OFF_OBS: rdata_d = {29'h0000_0000, dir_q, oe_q, out_q};
        default: rresp_d = dstp_pkg::DSTP_RESP_SLVERR;
      endcase
    end
    else if (rvalid_q && s_axi_rready)
      rvalid_d = 1'b0;
    arready_d = !rvalid_d;
  end

  // bus registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 5'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= dstp_pkg::DSTP_RESP_OKAY;
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= dstp_pkg::DSTP_RESP_OKAY;
    end
    else if (clk_en)
    begin
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  // ---------------------------------------------------------------
  // tick generation
  // ---------------------------------------------------------------
  // prescale factor minus one for each clock select code
  always_comb
  begin
    unique case (csel)
      3'h1: div_m1 = dstp_pkg::DSTP_DIV1;
      3'h2: div_m1 = dstp_pkg::DSTP_DIV8;
      3'h3: div_m1 = dstp_pkg::DSTP_DIV32;
      3'h4: div_m1 = dstp_pkg::DSTP_DIV64;
      3'h5: div_m1 = dstp_pkg::DSTP_DIV128;
      3'h6: div_m1 = dstp_pkg::DSTP_DIV256;
      3'h7: div_m1 = dstp_pkg::DSTP_DIV1024;
      default: div_m1 = dstp_pkg::DSTP_DIV1;
    endcase
  end

  // oscillator edge or every aclk cycle feeds the prescaler
  assign src_en = ctrl_q[dstp_pkg::DSTP_CTRL_ASYNC_BIT] ? (tosc_s2_q && !tosc_s3_q) : 1'b1;
  assign tick = pc_mode && (csel != 3'h0) && src_en && (pre_q == div_m1);

  // prescale counter restarts on each tick
  always_comb
  begin
    pre_d = pre_q;
    if (!pc_mode || csel == 3'h0)
      pre_d = 10'h000;
    else if (tick)
      pre_d = 10'h000;
    else if (src_en)
      pre_d = pre_q + 10'h001;
  end

  // oscillator synchroniser and prescaler registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tosc_s1_q <= 1'b0;
      tosc_s2_q <= 1'b0;
      tosc_s3_q <= 1'b0;
      pre_q <= 10'h000;
    end
    else if (clk_en)
    begin
      tosc_s1_q <= tosc;
      tosc_s2_q <= tosc_s1_q;
      tosc_s3_q <= tosc_s2_q;
      pre_q <= pre_d;
    end
  end

  // ---------------------------------------------------------------
  // dual slope counter and compare output
  // ---------------------------------------------------------------
  // count up to top, then turn at once and count back to bottom, neither end held for a second tick unless top is bottom
  always_comb
  begin
    cnt_d = cnt_q;
    dir_d = dir_q;
    if (tick)
    begin
      unique case (dir_q)
        dstp_pkg::DSTP_DIR_UP:
        begin
          if (cnt_q >= top)
          begin
            dir_d = dstp_pkg::DSTP_DIR_DOWN;
            cnt_d = (top == dstp_pkg::DSTP_BOTTOM) ? cnt_q : cnt_q - 8'h01;
          end
          else
            cnt_d = cnt_q + 8'h01;
        end
        dstp_pkg::DSTP_DIR_DOWN:
        begin
          if (cnt_q == dstp_pkg::DSTP_BOTTOM)
          begin
            dir_d = dstp_pkg::DSTP_DIR_UP;
            cnt_d = (top == dstp_pkg::DSTP_BOTTOM) ? cnt_q : cnt_q + 8'h01;
          end
          else
            cnt_d = cnt_q - 8'h01;
        end
      endcase
    end
    if (do_wr && awaddr_q == dstp_pkg::DSTP_OFF_CNT && wstrb_q[0])
      cnt_d = wdata_q[7:0];
  end

  assign at_top = tick && (cnt_d == top) && (dir_q == dstp_pkg::DSTP_DIR_UP);
  assign ovf_ev = tick && (cnt_d == dstp_pkg::DSTP_BOTTOM) && (cnt_q != dstp_pkg::DSTP_BOTTOM);
  assign match_ev = tick && (cnt_d == cmp_act_q);

  // output level follows from the slope and the position against compare,
  // so a missed match or a change away from max still lands on the right level
  always_comb
  begin
    if (cnt_d == dstp_pkg::DSTP_BOTTOM || (dir_d == dstp_pkg::DSTP_DIR_UP && cnt_d != top))
      level = cnt_d < cmp_act_q;
    else
      level = cnt_d <= cmp_act_q;
    out_d = out_q;
    if (tick && pwm_on)
      out_d = level ^ (omode == dstp_pkg::DSTP_OMODE_INV);
    oe_d = ctrl_q[dstp_pkg::DSTP_CTRL_PINDIR_BIT] && pwm_on && pc_mode;
  end

  // counter and output registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_q <= dstp_pkg::DSTP_BOTTOM;
      dir_q <= dstp_pkg::DSTP_DIR_UP;
      out_q <= 1'b0;
      oe_q <= 1'b0;
    end
    else if (clk_en)
    begin
      cnt_q <= cnt_d;
      dir_q <= dir_d;
      out_q <= out_d;
      oe_q <= oe_d;
    end
  end

  // ---------------------------------------------------------------
  // software registers and interrupt
  // ---------------------------------------------------------------
  // register writes, compare double buffering and sticky flags
  always_comb
  begin
    ctrl_d = ctrl_q;
    cmp_buf_d = cmp_buf_q;
    cmpa_buf_d = cmpa_buf_q;
    ien_d = ien_q;
    stat_d = stat_q;
    if (do_wr)
    begin
      unique case (awaddr_q)
        dstp_pkg::DSTP_OFF_CTRL: ctrl_d = (ctrl_q & ~wmask) | (wdata_q & wmask);
        dstp_pkg::DSTP_OFF_CMP: cmp_buf_d = wstrb_q[0] ? wdata_q[7:0] : cmp_buf_q;
        dstp_pkg::DSTP_OFF_CMPA: cmpa_buf_d = wstrb_q[0] ? wdata_q[7:0] : cmpa_buf_q;
        dstp_pkg::DSTP_OFF_IEN: ien_d = wstrb_q[0] ? wdata_q[1:0] : ien_q;
        dstp_pkg::DSTP_OFF_CLR: stat_d = wstrb_q[0] ? (stat_q & ~wdata_q[1:0]) : stat_q;
        default: ;
      endcase
    end
    // events set after the clear so that a set in the same cycle wins
    if (ovf_ev)
      stat_d[dstp_pkg::DSTP_ST_OVF_BIT] = 1'b1;
    if (match_ev)
      stat_d[dstp_pkg::DSTP_ST_MATCH_BIT] = 1'b1;
    // active compare values load at top, or at once while no phase correct mode is selected
    cmp_act_d = cmp_act_q;
    cmpa_act_d = cmpa_act_q;
    if (at_top || !pc_mode)
    begin
      cmp_act_d = cmp_buf_q;
      cmpa_act_d = cmpa_buf_q;
    end
    irq_d = |(stat_d & ien_d);
  end

  // software register state
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_q <= dstp_pkg::DSTP_CTRL_RST;
      cmp_buf_q <= dstp_pkg::DSTP_CMP_RST;
      cmp_act_q <= dstp_pkg::DSTP_CMP_RST;
      cmpa_buf_q <= dstp_pkg::DSTP_CMP_RST;
      cmpa_act_q <= dstp_pkg::DSTP_CMP_RST;
      stat_q <= 2'h0;
      ien_q <= 2'h0;
      irq_q <= 1'b0;
    end
    else if (clk_en)
    begin
      ctrl_q <= ctrl_d;
      cmp_buf_q <= cmp_buf_d;
      cmp_act_q <= cmp_act_d;
      cmpa_buf_q <= cmpa_buf_d;
      cmpa_act_q <= cmpa_act_d;
      stat_q <= stat_d;
      ien_q <= ien_d;
      irq_q <= irq_d;
    end
  end

  // outputs straight from flip-flops
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign compare_output = out_q;
  assign compare_output_oe = oe_q;
  assign irq = irq_q;

endmodule : dstp_timer_pwm

// [tb/dstp_timer_pwm_monitor.sv]
// checker for the dual slope pwm timer, watching its ports only
// assumes it is bound to dstp_timer_pwm and that clk_en is high during bus transfers
`timescale 1ns/1ps

module dstp_timer_pwm_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic compare_output,
  input wire logic compare_output_oe,
  input wire logic irq
);
  // ----------
  // properties
  // ----------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_bresp_hold:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_rdata_hold:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_read_latency:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer not one cycle after address");
  a_write_latency:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write answer not two cycles after handshake");
  a_busy_no_accept:
    assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  a_reset_release:
    assert property ($rose(aresetn) |-> !irq && !compare_output_oe
      ##1 s_axi_awready && s_axi_wready && s_axi_arready)
    else $error("outputs wrong after reset release");
  a_pwm_min_pulse:
    assert property ($rose(compare_output) |=> compare_output)
    else $error("pwm pulse of a single cycle");
  a_oe_on_write:
    assert property ($changed(compare_output_oe) |-> s_axi_bvalid || $past(s_axi_bvalid))
    else $error("pin direction changed without a register write");
endmodule : dstp_timer_pwm_monitor

bind dstp_timer_pwm dstp_timer_pwm_monitor mon (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .compare_output,
  .compare_output_oe, .irq);

// [tb/dstp_pwm_load.sv]
// load on the pwm pin: measures period, high time and steady run length
// assumes the timer clock and a pull-down on the pin
`timescale 1ns/1ps

module dstp_pwm_load (
  input wire logic aclk,
  input wire logic compare_output,
  input wire logic compare_output_oe,
  output logic pin,
  output logic [15:0] last_period,
  output logic [15:0] last_high,
  output logic [15:0] run_len
);
  logic pin_q = 1'h0;
  logic [15:0] per_q = 16'h0000;
  logic [15:0] hi_q = 16'h0000;

  // an undriven pin falls to the pull-down level
  assign pin = compare_output_oe ? compare_output : 1'h0;

  // measure from one rising edge of the pin to the next
  always_ff @(posedge aclk)
  begin
    pin_q <= pin;
    if (pin && !pin_q)
    begin
      last_period <= per_q;
      last_high <= hi_q;
      per_q <= 16'h0001;
      hi_q <= 16'h0001;
    end
    else
    begin
      per_q <= per_q + 16'h0001;
      hi_q <= hi_q + {15'h0000, pin};
    end
    run_len <= (pin != pin_q) ? 16'h0000 : run_len + {15'h0000, run_len != 16'hffff};
  end
endmodule : dstp_pwm_load

// [tb/dstp_timer_pwm_tb.sv]
// self-checking bench for the dual slope pwm timer
// assumes the design package, the load model and the checker compile first
`timescale 1ns/1ps

module dstp_timer_pwm_tb;
  // ----------
  // signals
  // ----------
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic clk_en = 1'h1;
  logic tosc = 1'h0;
  logic [4:0] s_axi_awaddr = 5'h00;
  logic s_axi_awvalid = 1'h0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_wvalid = 1'h0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'h0;
  logic [4:0] s_axi_araddr = 5'h00;
  logic s_axi_arvalid = 1'h0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'h0;
  logic compare_output;
  logic compare_output_oe;
  logic irq;
  logic pin;
  logic [15:0] last_period;
  logic [15:0] last_high;
  logic [15:0] run_len;
  logic [31:0] rd_data;
  logic [1:0] rd_resp;
  int fails = 0;
  int compares = 0;

  dstp_timer_pwm dut (.aclk, .aresetn, .clk_en, .tosc, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .compare_output,
    .compare_output_oe, .irq);

  dstp_pwm_load load (.aclk, .compare_output, .compare_output_oe, .pin, .last_period,
    .last_high, .run_len);

  // 250 MHz clock
  always #2 aclk = ~aclk;

  // ----------
  // helpers
  // ----------
  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // one write, address and data offered together
  task wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    s_axi_bready <= 1'h0;
    chk("bresp", s_axi_bresp, er);
  endtask : wr

  // one read, result left in rd_data and rd_resp
  task rd(input logic [4:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    s_axi_rready <= 1'h0;
    rd_data = s_axi_rdata;
    rd_resp = s_axi_rresp;
  endtask : rd

  function automatic logic [31:0] ctl(input logic [2:0] m, input logic [1:0] om,
    input logic [2:0] cs, input logic pd);
    ctl = {18'h0, 1'h0, pd, 1'h0, cs, 2'h0, om, 1'h0, m};
  endfunction : ctl

  // ----------
  // scenarios
  // ----------
  task t_reset;
    rd(dstp_pkg::DSTP_OFF_CTRL);
    chk("ctrl reset", rd_data, dstp_pkg::DSTP_CTRL_RST);
    rd(dstp_pkg::DSTP_OFF_CMP);
    chk("cmp reset", rd_data, {24'h0, dstp_pkg::DSTP_CMP_RST});
    rd(5'h02);
    chk("misaligned rresp", rd_resp, dstp_pkg::DSTP_RESP_SLVERR);
    chk("misaligned rdata", rd_data, 32'h0);
    wr(dstp_pkg::DSTP_OFF_STAT, 32'h3, dstp_pkg::DSTP_RESP_SLVERR);
    $display("test reset done");
  endtask : t_reset

  // only codes 1 and 5 run the counter and drive the pin
  task t_modes;
    int i;
    logic run;
    for (i = 0; i < 8; i++)
    begin
      run = (i == 1) || (i == 5);
      wr(dstp_pkg::DSTP_OFF_CTRL, ctl(3'(i), 2'h2, 3'h1, 1'h1), dstp_pkg::DSTP_RESP_OKAY);
      wr(dstp_pkg::DSTP_OFF_CNT, 32'h10, dstp_pkg::DSTP_RESP_OKAY);
      rd(dstp_pkg::DSTP_OFF_CNT);
      chk("counter moving", rd_data[7:0] !== 8'h10, run);
      chk("pin enable", compare_output_oe, run);
    end
    $display("test modes done");
  endtask : t_modes

  // period and duty for both output modes and one slower prescale
  task t_wave;
    int i;
    int dv;
    int h;
    for (i = 0; i < 3; i++)
    begin
      dv = (i == 2) ? 8 : 1;
      wr(dstp_pkg::DSTP_OFF_CMP, 32'h80, dstp_pkg::DSTP_RESP_OKAY);
      wr(dstp_pkg::DSTP_OFF_CTRL, ctl(3'h1, (i == 1) ? 2'h3 : 2'h2, (i == 2) ? 3'h2 : 3'h1, 1'h1),
        dstp_pkg::DSTP_RESP_OKAY);
      repeat (1100 * dv) @(posedge aclk);
      chk("period", last_period, dstp_pkg::DSTP_PERIOD_TICKS * dv);
      h = (i == 1) ? dstp_pkg::DSTP_PERIOD_TICKS - int'(last_high) : int'(last_high) / dv;
      chk("duty", (h >= 254) && (h <= 257), 1'h1);
    end
    $display("test wave done");
  endtask : t_wave

  // compare at bottom and at max, both output modes
  task t_limits;
    int i;
    logic [7:0] c;
    for (i = 0; i < 4; i++)
    begin
      c = i[0] ? 8'hff : 8'h00;
      wr(dstp_pkg::DSTP_OFF_CMP, {24'h0, c}, dstp_pkg::DSTP_RESP_OKAY);
      wr(dstp_pkg::DSTP_OFF_CTRL, ctl(3'h1, i[1] ? 2'h3 : 2'h2, 3'h1, 1'h1),
        dstp_pkg::DSTP_RESP_OKAY);
      repeat (1200) @(posedge aclk);
      chk("steady level", pin, i[0] ^ i[1]);
      chk("steady run", run_len >= 16'd600, 1'h1);
    end
    $display("test limits done");
  endtask : t_limits

  // compare value a as top, then pin direction input
  task t_top;
    wr(dstp_pkg::DSTP_OFF_CMPA, 32'h40, dstp_pkg::DSTP_RESP_OKAY);
    wr(dstp_pkg::DSTP_OFF_CMP, 32'h20, dstp_pkg::DSTP_RESP_OKAY);
    wr(dstp_pkg::DSTP_OFF_CTRL, ctl(3'h5, 2'h2, 3'h1, 1'h1), dstp_pkg::DSTP_RESP_OKAY);
    repeat (600) @(posedge aclk);
    chk("top period", last_period, 16'd128);
    wr(dstp_pkg::DSTP_OFF_CTRL, ctl(3'h1, 2'h2, 3'h1, 1'h0), dstp_pkg::DSTP_RESP_OKAY);
    repeat (4) @(posedge aclk);
    chk("pin released", compare_output_oe, 1'h0);
    $display("test top done");
  endtask : t_top

  // overflow flag, interrupt enable, mask and clear
  task t_irq;
    wr(dstp_pkg::DSTP_OFF_CTRL, ctl(3'h1, 2'h2, 3'h1, 1'h1), dstp_pkg::DSTP_RESP_OKAY);
    wr(dstp_pkg::DSTP_OFF_IEN, 32'h1, dstp_pkg::DSTP_RESP_OKAY);
    repeat (600) @(posedge aclk);
    rd(dstp_pkg::DSTP_OFF_STAT);
    chk("overflow flag", rd_data[dstp_pkg::DSTP_ST_OVF_BIT], 1'h1);
    chk("irq raised", irq, 1'h1);
    wr(dstp_pkg::DSTP_OFF_IEN, 32'h0, dstp_pkg::DSTP_RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk("irq masked", irq, 1'h0);
    wr(dstp_pkg::DSTP_OFF_CTRL, ctl(3'h1, 2'h2, 3'h0, 1'h1), dstp_pkg::DSTP_RESP_OKAY);
    wr(dstp_pkg::DSTP_OFF_CLR, 32'h3, dstp_pkg::DSTP_RESP_OKAY);
    rd(dstp_pkg::DSTP_OFF_STAT);
    chk("status cleared", rd_data, 32'h0);
    wr(dstp_pkg::DSTP_OFF_IEN, 32'h1, dstp_pkg::DSTP_RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk("irq after clear", irq, 1'h0);
    $display("test irq done");
  endtask : t_irq

  // one rising edge of the timer oscillator, slow against aclk
  task tosc_pulse;
    repeat (3) @(posedge aclk);
    tosc <= 1'h1;
    repeat (3) @(posedge aclk);
    tosc <= 1'h0;
  endtask : tosc_pulse

  // oscillator edges step the counter, a low clock enable freezes it;
  // starting at top makes the count independent of the old direction
  task t_async;
    wr(dstp_pkg::DSTP_OFF_CTRL, ctl(3'h1, 2'h2, 3'h1, 1'h1) | (32'h1 << dstp_pkg::DSTP_CTRL_ASYNC_BIT),
      dstp_pkg::DSTP_RESP_OKAY);
    wr(dstp_pkg::DSTP_OFF_CNT, 32'hff, dstp_pkg::DSTP_RESP_OKAY);
    repeat (20) tosc_pulse;
    repeat (8) @(posedge aclk);
    rd(dstp_pkg::DSTP_OFF_CNT);
    chk("oscillator count", rd_data, 32'h0000_00eb);
    clk_en <= 1'h0;
    repeat (20) tosc_pulse;
    clk_en <= 1'h1;
    repeat (8) @(posedge aclk);
    rd(dstp_pkg::DSTP_OFF_CNT);
    chk("frozen count", rd_data, 32'h0000_00eb);
    $display("test async done");
  endtask : t_async

  // ----------
  // run control
  // ----------
  task report_and_stop;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop

  // main sequence after a 16 cycle reset
  initial
  begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    t_reset;
    t_modes;
    t_wave;
    t_limits;
    t_top;
    t_irq;
    t_async;
    report_and_stop;
  end

  // watchdog well beyond the expected run length
  initial
  begin
    repeat (40000) @(posedge aclk);
    fails++;
    $display("ERROR watchdog expected finish seen hang");
    report_and_stop;
  end
endmodule : dstp_timer_pwm_tb
